// >>> core/fsx_status_unit.sv
// Floating status word, exception handling and condition codes of the floating unit
//
// Overview of operation
// - Status bits 13, 12 and 4 are reserved, read zero and do nothing.
// - Undefined-variable enable traps minus zero fetched from memory by listed instructions.
// - That trap comes before execution, except negate, absolute and test: after.
// - Undefined-variable enable clear: minus zero operands are accepted silently.
// - Minus zero in an accumulator operand, mode 0, never traps.
// - A minus zero result is never written without an interrupt.
// - Underflow enabled: interrupt, correct fraction, exponent 400 octal high unless zero.
// - Underflow disabled: no interrupt, result becomes exact zero.
// - Overflow enabled: interrupt, correct fraction, exponent 400 octal low.
// - Overflow disabled: no interrupt, result becomes exact zero.
// - Failed conversion zeroes destination only, interrupts when conversion enable set.
// - Conversion enable clear: same zeroed destination, no interrupt.
// - Conversion fails when the integer overflows the width the long mode selects.
// - Precision bit set selects double precision, clear selects single.
// - Long mode bit selects 32-bit integers, clear selects 16-bit.
// - Chop bit set truncates results, clear rounds them.
// - Negative flag follows the sign of the last result.
// - Zero flag follows whether the last result was zero.
// - Overflow flag follows whether the last operation overflowed the exponent.
// - Carry flag marks a failed conversion; floating results clear it.
// - Error flag set by divide by zero, bad opcode, enabled exception; only load clears.
// - Global disable suppresses every floating interrupt request.
`timescale 1ns/1ps
`default_nettype none
`include "fsx_map.svh"
module fsx_status_unit
   import fsx_pkg::*;
#(
   parameter int FRAC_W = `FSX_DBL_FRAC_W,
   parameter int SGL_W = `FSX_SGL_FRAC_W,
   parameter int INT_W = `FSX_INT_W
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,

   input wire logic load_status,
   input wire logic [15:0] load_data,
   output logic [15:0] floating_status_word,
   output logic double_precision_mode,
   output logic long_integer_mode,
   output logic chop_mode,

   input wire logic operand_valid,
   input wire fsx_pkg::fsx_op_type operand_op,
   input wire logic [2:0] operand_mode,
   input wire logic operand_minus_zero,
   output logic undef_trap_before,

   input wire logic op_valid,
   input wire fsx_pkg::fsx_op_type op_type,
   input wire logic raw_sign,
   input wire logic signed [9:0] raw_exp,
   input wire logic [FRAC_W:0] raw_frac,
   input wire logic raw_zero,
   input wire logic signed [INT_W-1:0] int_value,
   input wire logic divide_by_zero,
   input wire logic illegal_opcode,

   output logic result_valid,
   output logic result_sign,
   output logic [7:0] result_exp,
   output logic [FRAC_W-1:0] result_frac,
   output logic [31:0] int_dest,

   output logic float_irq_req,
   input wire logic irq_ack
);
   import fsx_pkg::*;

   localparam logic [15:0] STATUS_RESET = `FSX_STATUS_RESET;

   // Synchronised copy of the reset
   logic [1:0] rst_sync;
   logic rst_n;

   logic error_flag;
   logic global_irq_disable;
   logic undef_var_irq_enable;
   logic underflow_irq_enable;
   logic overflow_irq_enable;
   logic conversion_error_irq_enable;

   // Condition codes of the last instruction
   logic negative_flag;
   logic zero_flag;
   logic overflow_flag;
   logic carry_flag;

   // Negate, absolute and test traps wait here
   fsx_defer_type defer_state;
   fsx_defer_type next_defer_state;

   logic checked_op;
   logic undef_hit;
   logic undef_now;
   logic undef_later;
   logic defer_fire;

   logic conv_op;
   logic float_op;
   logic exc_event;
   logic err_event;
   logic irq_event;

   logic next_neg;
   logic next_zero;
   logic next_ovfl;
   logic next_carry;

   fsx_calc_if #(.FRAC_W(FRAC_W), .INT_W(INT_W)) calc ();

   // Reset is released through two flops so every flop leaves reset on the same edge
   // Frozen by the clock enable like every other flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else if (ce) begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Inputs of the result helper
   assign calc.double_mode = double_precision_mode;
   assign calc.chop_mode = chop_mode;
   assign calc.over_en = overflow_irq_enable;
   assign calc.under_en = underflow_irq_enable;
   assign calc.irq_allowed = !global_irq_disable;
   assign calc.raw_sign = raw_sign;
   assign calc.raw_exp = raw_exp;
   assign calc.raw_frac = raw_frac;
   assign calc.raw_zero = raw_zero;

   // Inputs of the conversion helper
   assign calc.long_mode = long_integer_mode;
   assign calc.int_value = int_value;

   // Rounding, range check and substitution
   fsx_float_round #(.FRAC_W(FRAC_W), .SGL_W(SGL_W)) u_round (
      .io(calc.res_calc)
   );

   // Integer range check
   fsx_int_convert #(.INT_W(INT_W)) u_conv (
      .io(calc.conv_calc)
   );

   // Undefined-variable detection on operand fetch
   always_comb begin
      // Conversions and other classes fetch nothing that can trap
      checked_op = (operand_op == FSX_OP_ARITH)
         || (operand_op == FSX_OP_LOAD)
         || (operand_op == FSX_OP_NAT);
      undef_hit = operand_valid && operand_minus_zero && checked_op && undef_var_irq_enable
         && (operand_mode != `FSX_ACC_MODE);
      undef_now = undef_hit && (operand_op != FSX_OP_NAT);
      undef_later = undef_hit && (operand_op == FSX_OP_NAT);
      defer_fire = op_valid && (defer_state == FSX_ST_DEFER);
   end

   // A trap on negate, absolute or test waits for that instruction to finish
   always_comb begin
      case (defer_state)
         FSX_ST_IDLE: begin
            next_defer_state = undef_later ? FSX_ST_DEFER : FSX_ST_IDLE;
         end
         FSX_ST_DEFER: begin
            next_defer_state = op_valid ? FSX_ST_IDLE : FSX_ST_DEFER;
         end
         default: begin
            next_defer_state = FSX_ST_IDLE;
         end
      endcase
   end

   // A second deferred trap before completion merges with the first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         defer_state <= FSX_ST_IDLE;
      end else if (ce) begin
         defer_state <= next_defer_state;
      end
   end

   // Exception classification for the instruction completing this cycle
   always_comb begin
      conv_op = (op_type == FSX_OP_CONV);
      float_op = !conv_op && (op_type != FSX_OP_OTHER);
      exc_event = (float_op && calc.exc_enabled)
         || (conv_op && calc.conv_fail && conversion_error_irq_enable)
         || defer_fire;
      err_event = undef_now
         || (op_valid && (divide_by_zero || illegal_opcode || exc_event));
      // The error flag ignores the global disable; only the request is gated
      irq_event = err_event && !global_irq_disable;
   end

   // Condition codes of the finishing instruction
   always_comb begin
      if (conv_op) begin
         next_neg = long_integer_mode ? calc.conv_dest[`FSX_LONG_W-1] : calc.conv_dest[`FSX_SHORT_W-1];
         next_zero = (calc.conv_dest == 32'h0000_0000);
         next_ovfl = 1'b0;
         next_carry = calc.conv_fail;
      end else begin
         // Negative and zero flags follow the stored, already substituted result; overflow follows the range check
         next_neg = calc.st_sign;
         next_zero = (calc.st_exp == 8'h00);
         next_ovfl = float_op && calc.over;
         next_carry = 1'b0;
      end
   end

   // Mode and enable bits change only through a status load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_disable <= STATUS_RESET[`FSX_BIT_IRQ_DIS];
         undef_var_irq_enable <= STATUS_RESET[`FSX_BIT_UNDEF_EN];
         underflow_irq_enable <= STATUS_RESET[`FSX_BIT_UNDER_EN];
         overflow_irq_enable <= STATUS_RESET[`FSX_BIT_OVER_EN];
         conversion_error_irq_enable <= STATUS_RESET[`FSX_BIT_CONV_EN];
         double_precision_mode <= STATUS_RESET[`FSX_BIT_DOUBLE];
         long_integer_mode <= STATUS_RESET[`FSX_BIT_LONG];
         chop_mode <= STATUS_RESET[`FSX_BIT_CHOP];
      end else if (ce && load_status) begin
         // Reserved positions of load_data are never stored
         global_irq_disable <= load_data[`FSX_BIT_IRQ_DIS];
         undef_var_irq_enable <= load_data[`FSX_BIT_UNDEF_EN];
         underflow_irq_enable <= load_data[`FSX_BIT_UNDER_EN];
         overflow_irq_enable <= load_data[`FSX_BIT_OVER_EN];
         conversion_error_irq_enable <= load_data[`FSX_BIT_CONV_EN];
         double_precision_mode <= load_data[`FSX_BIT_DOUBLE];
         long_integer_mode <= load_data[`FSX_BIT_LONG];
         chop_mode <= load_data[`FSX_BIT_CHOP];
      end
   end

   // Condition codes: a finishing instruction overrides a load in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         negative_flag <= STATUS_RESET[`FSX_BIT_NEG];
         zero_flag <= STATUS_RESET[`FSX_BIT_ZERO];
         overflow_flag <= STATUS_RESET[`FSX_BIT_OVFL];
         carry_flag <= STATUS_RESET[`FSX_BIT_CARRY];
      end else if (ce) begin
         if (op_valid) begin
            negative_flag <= next_neg;
            zero_flag <= next_zero;
            overflow_flag <= next_ovfl;
            carry_flag <= next_carry;
         end else if (load_status) begin
            negative_flag <= load_data[`FSX_BIT_NEG];
            zero_flag <= load_data[`FSX_BIT_ZERO];
            overflow_flag <= load_data[`FSX_BIT_OVFL];
            carry_flag <= load_data[`FSX_BIT_CARRY];
         end
      end
   end

   // Error flag is sticky; a new error in the cycle of a load still sets it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         error_flag <= STATUS_RESET[`FSX_BIT_ERROR];
      end else if (ce) begin
         if (err_event) begin
            error_flag <= 1'b1;
         end else if (load_status) begin
            error_flag <= load_data[`FSX_BIT_ERROR];
         end
      end
   end

   // Single request level held until the core acknowledges it; a new event beats the acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         float_irq_req <= 1'b0;
      end else if (ce) begin
         if (irq_event) begin
            float_irq_req <= 1'b1;
         end else if (irq_ack) begin
            float_irq_req <= 1'b0;
         end
      end
   end

   // Trap taken before execution, so the core can abandon the instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         undef_trap_before <= 1'b0;
      end else if (ce) begin
         undef_trap_before <= undef_now;
      end
   end

   // Stored results, already substituted, one cycle after completion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_valid <= 1'b0;
         result_sign <= 1'b0;
         result_exp <= 8'h00;
         result_frac <= '0;
         int_dest <= 32'h0000_0000;
      end else if (ce) begin
         result_valid <= op_valid;
         // A conversion touches only its integer destination
         if (op_valid && float_op) begin
            result_sign <= calc.st_sign;
            result_exp <= calc.st_exp;
            result_frac <= calc.st_frac;
         end
         if (op_valid && conv_op) begin
            int_dest <= calc.conv_dest;
         end
      end
   end

   // Reserved positions read zero
   assign floating_status_word = {
      error_flag,
      global_irq_disable,
      2'b00,
      undef_var_irq_enable,
      underflow_irq_enable,
      overflow_irq_enable,
      conversion_error_irq_enable,
      double_precision_mode,
      long_integer_mode,
      chop_mode,
      1'b0,
      negative_flag,
      zero_flag,
      overflow_flag,
      carry_flag
   };
endmodule
`default_nettype wire

// >>> core/fsx_map.svh
// Bit positions, reset value, widths and limits of the floating status logic
`ifndef FSX_MAP_SVH
`define FSX_MAP_SVH
`define FSX_BIT_ERROR 15
`define FSX_BIT_IRQ_DIS 14
`define FSX_BIT_UNDEF_EN 11
`define FSX_BIT_UNDER_EN 10
`define FSX_BIT_OVER_EN 9
`define FSX_BIT_CONV_EN 8
`define FSX_BIT_DOUBLE 7
`define FSX_BIT_LONG 6
`define FSX_BIT_CHOP 5
`define FSX_BIT_NEG 3
`define FSX_BIT_ZERO 2
`define FSX_BIT_OVFL 1
`define FSX_BIT_CARRY 0
`define FSX_STATUS_RESET 16'h0000
`define FSX_EXP_MAX 10'sh0FF
`define FSX_EXP_MIN 10'sh001
`define FSX_SGL_FRAC_W 23
`define FSX_DBL_FRAC_W 55
`define FSX_SHORT_W 16
`define FSX_LONG_W 32
`define FSX_INT_W 64
`define FSX_ACC_MODE 3'h0
`endif

// >>> core/fsx_pkg.sv
// Types shared by the floating status logic
package fsx_pkg;
   typedef enum logic [4:0] {
      FSX_OP_ARITH = 5'h01,
      FSX_OP_LOAD = 5'h02,
      FSX_OP_NAT = 5'h04,
      FSX_OP_CONV = 5'h08,
      FSX_OP_OTHER = 5'h10
   } fsx_op_type;
   typedef enum logic [1:0] {
      FSX_ST_IDLE = 2'h1,
      FSX_ST_DEFER = 2'h2
   } fsx_defer_type;
endpackage

// >>> core/fsx_calc_if.sv
// Signals between the status unit and its result and conversion helpers
`timescale 1ns/1ps
`default_nettype none
interface fsx_calc_if #(
   parameter int FRAC_W = 55,
   parameter int INT_W = 64
);
   logic double_mode;
   logic chop_mode;
   logic over_en;
   logic under_en;
   logic irq_allowed;
   logic raw_sign;
   logic signed [9:0] raw_exp;
   logic [FRAC_W:0] raw_frac;
   logic raw_zero;
   logic st_sign;
   logic [7:0] st_exp;
   logic [FRAC_W-1:0] st_frac;
   logic over;
   logic under;
   logic exc_enabled;
   logic long_mode;
   logic signed [INT_W-1:0] int_value;
   logic conv_fail;
   logic [31:0] conv_dest;
   modport res_calc(input double_mode, chop_mode, over_en, under_en, irq_allowed, raw_sign, raw_exp,
      raw_frac, raw_zero, output st_sign, st_exp, st_frac, over, under, exc_enabled);
   modport res_user(output double_mode, chop_mode, over_en, under_en, irq_allowed, raw_sign, raw_exp,
      raw_frac, raw_zero, input st_sign, st_exp, st_frac, over, under, exc_enabled);
   modport conv_calc(input long_mode, int_value, output conv_fail, conv_dest);
   modport conv_user(output long_mode, int_value, input conv_fail, conv_dest);
endinterface
`default_nettype wire

// >>> core/fsx_float_round.sv
// Rounding, exponent range check and result substitution for one float result
`timescale 1ns/1ps
`default_nettype none
`include "fsx_map.svh"
module fsx_float_round #(
   parameter int FRAC_W = 55,
   parameter int SGL_W = 23
) (
   fsx_calc_if.res_calc io
);
   localparam logic [FRAC_W-1:0] SGL_LSB = FRAC_W'(1) << (FRAC_W - SGL_W);
   localparam logic [FRAC_W-1:0] SGL_MASK = ~(SGL_LSB - FRAC_W'(1));
   logic [FRAC_W-1:0] kept;
   logic [FRAC_W-1:0] lsb;
   logic rnd_bit;
   logic [FRAC_W:0] sum;
   logic signed [9:0] exp_adj;
   logic ovf;
   logic unf;
   logic enabled;
   logic neg_zero;
   logic wipe;

   always_comb begin
      if (io.double_mode) begin
         kept = io.raw_frac[FRAC_W:1];
         rnd_bit = io.raw_frac[0];
         lsb = FRAC_W'(1);
      end else begin
         kept = io.raw_frac[FRAC_W:1] & SGL_MASK;
         rnd_bit = io.raw_frac[FRAC_W-SGL_W];
         lsb = SGL_LSB;
      end
      // Chop drops the rounding bit, round adds one LSB when it is set
      sum = {1'b0, kept} + ((rnd_bit && !io.chop_mode) ? {1'b0, lsb} : '0);
      exp_adj = io.raw_exp + {9'h000, sum[FRAC_W]};
      ovf = !io.raw_zero && (exp_adj > `FSX_EXP_MAX);
      unf = !io.raw_zero && (exp_adj < `FSX_EXP_MIN);
      enabled = (ovf && io.over_en) || (unf && io.under_en);
      // Low eight exponent bits kept: overflow reads 400 octal low, underflow 400 high
      neg_zero = io.raw_sign && (exp_adj[7:0] == 8'h00);
      wipe = io.raw_zero || (ovf && !io.over_en) || (unf && !io.under_en)
         || (neg_zero && !(enabled && io.irq_allowed));
      io.st_sign = wipe ? 1'b0 : io.raw_sign;
      io.st_exp = wipe ? 8'h00 : exp_adj[7:0];
      io.st_frac = wipe ? '0 : sum[FRAC_W-1:0];
      io.over = ovf;
      io.under = unf;
      io.exc_enabled = enabled;
   end
endmodule
`default_nettype wire

// >>> core/fsx_int_convert.sv
// Range check of a float to integer conversion against the selected integer width
`timescale 1ns/1ps
`default_nettype none
`include "fsx_map.svh"
module fsx_int_convert #(
   parameter int INT_W = 64
) (
   fsx_calc_if.conv_calc io
);
   logic fits_short;
   logic fits_long;

   always_comb begin
      fits_short = (&io.int_value[INT_W-1:`FSX_SHORT_W-1]) || !(|io.int_value[INT_W-1:`FSX_SHORT_W-1]);
      fits_long = (&io.int_value[INT_W-1:`FSX_LONG_W-1]) || !(|io.int_value[INT_W-1:`FSX_LONG_W-1]);
      io.conv_fail = io.long_mode ? !fits_long : !fits_short;
      if (io.conv_fail) begin
         io.conv_dest = 32'h0000_0000;
      end else if (io.long_mode) begin
         io.conv_dest = io.int_value[`FSX_LONG_W-1:0];
      end else begin
         io.conv_dest = {{`FSX_SHORT_W{io.int_value[`FSX_SHORT_W-1]}}, io.int_value[`FSX_SHORT_W-1:0]};
      end
   end
endmodule
`default_nettype wire

// >>> testbench/fsx_status_checker.sv
// Port checks of the floating status unit
`timescale 1ns/1ps
`default_nettype none
module fsx_status_checker
   import fsx_pkg::*;
#(
   parameter int INT_W = 64
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic load_status,
   input wire logic [15:0] load_data,
   input wire logic [15:0] floating_status_word,
   input wire logic long_integer_mode,
   input wire logic operand_valid,
   input wire fsx_pkg::fsx_op_type operand_op,
   input wire logic [2:0] operand_mode,
   input wire logic operand_minus_zero,
   input wire logic undef_trap_before,
   input wire logic op_valid,
   input wire fsx_pkg::fsx_op_type op_type,
   input wire logic signed [INT_W-1:0] int_value,
   input wire logic result_valid,
   input wire logic result_sign,
   input wire logic [7:0] result_exp,
   input wire logic [31:0] int_dest,
   input wire logic float_irq_req,
   input wire logic irq_ack
);
   logic bad;
   logic [15:0] w;
   assign w = floating_status_word;
   assign bad = long_integer_mode ? int_value[INT_W-1:31] != {(INT_W-31){int_value[31]}}
      : int_value[INT_W-1:15] != {(INT_W-15){int_value[15]}};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n || !ce);
   AST_RESERVED: assert property (load_status && !op_valid
      |=> (w & 16'h3010) == 16'h0000 && w[11:5] == $past(load_data[11:5])) else $error("status load wrong");
   AST_UNDEF_TRAP: assert property (operand_valid && operand_minus_zero && operand_mode != 3'h0 && w[11]
      && (operand_op == FSX_OP_ARITH || operand_op == FSX_OP_LOAD) |=> undef_trap_before && w[15]) else $error("no trap");
   AST_NO_TRAP: assert property (operand_valid && (operand_mode == 3'h0 || !w[11] || operand_op == FSX_OP_NAT)
      |=> !undef_trap_before) else $error("unexpected trap");
   AST_NO_MINUS_ZERO: assert property (result_valid && result_sign && result_exp == 8'h00 |-> float_irq_req)
      else $error("minus zero stored silently");
   AST_IRQ_OFF: assert property ($past(w[14]) && w[14] |-> !$rose(float_irq_req))
      else $error("request while disabled");
   AST_ERR_STICKY: assert property ($past(w[15]) && !$past(load_status) |-> w[15])
      else $error("error flag dropped");
   AST_CONV: assert property (op_valid && op_type == FSX_OP_CONV |=> w[0] == $past(bad) && !w[1]
      && int_dest == ($past(bad) ? 32'h0 : $past(int_value[31:0]))) else $error("conversion wrong");
   AST_ACK: assert property (irq_ack && !op_valid && !operand_valid |=> !float_irq_req)
      else $error("request not cleared");
endmodule
bind fsx_status_unit fsx_status_checker #(.INT_W(INT_W)) chk_i (.clk, .arst_n, .ce, .load_status, .load_data,
   .floating_status_word, .long_integer_mode, .operand_valid, .operand_op, .operand_mode, .operand_minus_zero,
   .undef_trap_before, .op_valid, .op_type, .int_value, .result_valid, .result_sign, .result_exp, .int_dest,
   .float_irq_req, .irq_ack);
`default_nettype wire

// >>> testbench/fsx_core_model.sv
// Host core model issuing status loads, operand fetches, completions and acknowledges
`timescale 1ns/1ps
`default_nettype none
module fsx_core_model
   import fsx_pkg::*;
(
   input wire logic clk,
   output logic load_status,
   output logic [15:0] load_data,
   output logic operand_valid,
   output fsx_pkg::fsx_op_type operand_op,
   output logic [2:0] operand_mode,
   output logic operand_minus_zero,
   output logic op_valid,
   output fsx_pkg::fsx_op_type op_type,
   output logic raw_sign,
   output logic signed [9:0] raw_exp,
   output logic [55:0] raw_frac,
   output logic raw_zero,
   output logic signed [63:0] int_value,
   output logic divide_by_zero,
   output logic illegal_opcode,
   output logic irq_ack
);
   initial begin
      {load_status, operand_valid, op_valid, irq_ack, divide_by_zero, illegal_opcode} = '0;
      {load_data, operand_mode, operand_minus_zero, raw_sign, raw_exp, raw_frac, raw_zero, int_value} = '0;
      operand_op = FSX_OP_OTHER;
      op_type = FSX_OP_OTHER;
   end
   // Strobes last one cycle; released data is inverted so a stale value never passes as fresh
   task automatic load(input logic [15:0] d);
      @(negedge clk);
      load_status = 1'b1;
      load_data = d;
      @(negedge clk);
      load_status = 1'b0;
      load_data = ~d;
   endtask
   task automatic fetch(input fsx_op_type op, input logic [2:0] m, input logic mz);
      @(negedge clk);
      operand_valid = 1'b1;
      operand_op = op;
      {operand_mode, operand_minus_zero} = {m, mz};
      @(negedge clk);
      operand_valid = 1'b0;
      {operand_mode, operand_minus_zero} = ~{m, mz};
   endtask
   task automatic finish(input fsx_op_type t, input logic s, input logic signed [9:0] e, input logic [55:0] f,
      input logic z, input logic signed [63:0] v, input logic dz, input logic il);
      @(negedge clk);
      op_valid = 1'b1;
      op_type = t;
      {raw_sign, raw_exp, raw_frac, raw_zero, int_value, divide_by_zero, illegal_opcode} = {s, e, f, z, v, dz, il};
      @(negedge clk);
      op_valid = 1'b0;
      {raw_sign, raw_exp, raw_frac, raw_zero, int_value} = ~{s, e, f, z, v};
   endtask
   task automatic ack();
      @(negedge clk);
      irq_ack = 1'b1;
      @(negedge clk);
      irq_ack = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/tb_fp_status_exception_control.sv
// Self-checking bench of the floating status unit against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb_fp_status_exception_control;
   import fsx_pkg::*;
   logic clk, arst_n, ce, load_status, operand_valid, operand_minus_zero, op_valid, raw_sign, raw_zero;
   logic divide_by_zero, illegal_opcode, irq_ack, double_precision_mode, long_integer_mode, chop_mode;
   logic undef_trap_before, result_valid, result_sign, float_irq_req;
   logic [15:0] load_data, floating_status_word, sw, d;
   logic [2:0] operand_mode, m;
   logic signed [9:0] raw_exp, e;
   logic [55:0] raw_frac, f;
   logic signed [63:0] int_value;
   logic [7:0] result_exp, xe;
   logic [54:0] result_frac, fr;
   logic [31:0] int_dest, dst;
   logic [23:0] t24;
   logic rq, pend, trap, mz, s, z, dz, il, c, rb, fail, ev, ov, un, xs;
   fsx_op_type operand_op, op_type, t;
   longint v, lim;
   longint edge_v[9] = '{64'sh7FFF, 64'sh8000, -64'sh8000, -64'sh8001, 64'sh7FFFFFFF, 64'sh80000000,
      -64'sh80000000, -64'sh80000001, 64'sh0};
   int ex, i;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   fsx_status_unit dut (.clk, .arst_n, .ce, .load_status, .load_data, .floating_status_word, .double_precision_mode,
      .long_integer_mode, .chop_mode, .operand_valid, .operand_op, .operand_mode, .operand_minus_zero,
      .undef_trap_before, .op_valid, .op_type, .raw_sign, .raw_exp, .raw_frac, .raw_zero, .int_value,
      .divide_by_zero, .illegal_opcode, .result_valid, .result_sign, .result_exp, .result_frac, .int_dest,
      .float_irq_req, .irq_ack);
   fsx_core_model core (.clk, .load_status, .load_data, .operand_valid, .operand_op, .operand_mode,
      .operand_minus_zero, .op_valid, .op_type, .raw_sign, .raw_exp, .raw_frac, .raw_zero, .int_value,
      .divide_by_zero, .illegal_opcode, .irq_ack);
   task automatic report_and_stop();
      if (err_total == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] want);
      compares++;
      if (seen !== want) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic chk_state();
      chk("status", 64'(floating_status_word), 64'(sw));
      chk("irq", 64'(float_irq_req), 64'(rq));
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // About 2400 cycles are expected; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      ce = 1'b1;
      arst_n = 1'b0;
      rq = 1'b0;
      pend = 1'b0;
      sw = 16'h0000;
      i = $urandom(32'h7EAD);
      repeat (2) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk_state();
      for (i = 0; i < 400; i++) begin
         d = 16'($urandom);
         if ($urandom % 4 != 0)
            d[14] = 1'b0;
         core.load(d);
         sw = d & 16'hCFEF;
         chk_state();
         chk("modes", 64'({double_precision_mode, long_integer_mode, chop_mode}), 64'(sw[7:5]));
         trap = 1'b0;
         if ($urandom % 2 == 0) begin
            t = fsx_op_type'(5'h01 << ($urandom % 5));
            m = 3'($urandom % 4);
            mz = ($urandom % 4) != 0;
            core.fetch(t, m, mz);
            trap = sw[11] && mz && m != 3'h0 && (t == FSX_OP_ARITH || t == FSX_OP_LOAD);
            pend = sw[11] && mz && m != 3'h0 && t == FSX_OP_NAT;
            sw[15] = sw[15] | trap;
            rq = rq | (trap & !sw[14]);
            chk("trap_before", 64'(undef_trap_before), 64'(trap));
            chk_state();
         end
         if (!trap) begin
            t = fsx_op_type'(5'h01 << ($urandom % 4));
            s = 1'($urandom);
            e = 10'(int'($urandom % 600) - 200);
            f = ($urandom % 8 == 0) ? '1 : 56'({$urandom, $urandom});
            z = $urandom % 8 == 0;
            if (z)
               {s, e, f} = '0;
            v = ($urandom % 2 == 1) ? edge_v[$urandom % 9] : longint'(int'($urandom));
            dz = $urandom % 8 == 0;
            il = $urandom % 8 == 0;
            core.finish(t, s, e, f, z, v, dz, il);
            ev = dz | il | pend;
            pend = 1'b0;
            if (t == FSX_OP_CONV) begin
               lim = sw[6] ? 64'sh7FFFFFFF : 64'sh7FFF;
               fail = v > lim || v < -lim - 1;
               dst = fail ? 32'h0 : 32'(v);
               ev = ev | (fail & sw[8]);
               sw[3:0] = {dst[31], dst == 32'h0, 1'b0, fail};
               chk("int_dest", 64'(int_dest), 64'(dst));
            end else begin
               rb = sw[5] ? 1'b0 : (sw[7] ? f[0] : f[32]);
               if (sw[7]) begin
                  {c, fr} = {1'b0, f[55:1]} + 56'(rb);
               end else begin
                  t24 = {1'b0, f[55:33]} + 24'(rb);
                  c = t24[23];
                  fr = {t24[22:0], 32'h0};
               end
               ex = int'(e) + int'(c);
               ov = ex > 255;
               un = ex < 1 && !z;
               xs = s;
               xe = 8'(ex);
               ev = ev | (ov & sw[9]) | (un & sw[10]);
               if ((ov && !sw[9]) || (un && !sw[10]) || z || (xs && xe == 8'h00 && !(ev && !sw[14])))
                  {xs, xe, fr} = 64'h0;
               sw[3:0] = {xs, xe == 8'h00, ov, 1'b0};
               chk("result", {result_sign, result_exp, result_frac}, {xs, xe, fr});
            end
            sw[15] = sw[15] | ev;
            rq = rq | (ev & !sw[14]);
            chk_state();
         end
         if ($urandom % 2 == 0) begin
            core.ack();
            rq = 1'b0;
            chk_state();
         end
         // With the clock enable low a load must not land
         if (i % 50 == 49) begin
            ce = 1'b0;
            core.load(~sw);
            ce = 1'b1;
            chk_state();
         end
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
